// ### inc/adcsq_defs.svh
// Offsets, field positions, reset values and timing counts of the sequencer
// Assumes inclusion by the design files and the bench by bare name
`ifndef ADCSQ_DEFS_SVH
`define ADCSQ_DEFS_SVH

`define ADCSQ_OFF_CTRL1 12'h000
`define ADCSQ_OFF_CTRL2 12'h004
`define ADCSQ_OFF_CTRL3 12'h008
`define ADCSQ_OFF_INSEL 12'h00C
`define ADCSQ_OFF_SCAN 12'h010
`define ADCSQ_OFF_STAT 12'h014

`define ADCSQ_CTRL1_MASK 32'h000080E4
`define ADCSQ_CTRL2_MASK 32'h0000F43F
`define ADCSQ_CTRL3_MASK 32'h00009FFF
`define ADCSQ_INSEL_MASK 32'h8F8F0000
`define ADCSQ_SCAN_MASK 32'h0000FFFF
`define ADCSQ_RESET_VALUE 32'h00000000

`define ADCSQ_BIT_ON 15
`define ADCSQ_TRIG_LSB 5
`define ADCSQ_BIT_ASAM 2
`define ADCSQ_BIT_SAMP_START 1
`define ADCSQ_REF_LSB 13
`define ADCSQ_BIT_OFFSET_CALIBRATION_ENABLE 12
`define ADCSQ_BIT_SCAN 10
`define ADCSQ_BIT_FILL 7
`define ADCSQ_SPI_LSB 2
`define ADCSQ_BIT_SPLIT 1
`define ADCSQ_BIT_ALT 0
`define ADCSQ_BIT_CLKSRC 15
`define ADCSQ_SAMT_LSB 8
`define ADCSQ_DIV_LSB 0
`define ADCSQ_BIT_NEG_B 31
`define ADCSQ_POS_B_LSB 24
`define ADCSQ_BIT_NEG_A 23
`define ADCSQ_POS_A_LSB 16

`define ADCSQ_TRIG_AUTO 3'h7
`define ADCSQ_POS_TEMP 4'hD
`define ADCSQ_POS_IREF 4'hE
`define ADCSQ_POS_OPEN 4'hF
`define ADCSQ_NUM_PINS 13
`define ADCSQ_HALF_BASE 4'h8
`define ADCSQ_CONV_TADS 5'h0C

`endif

// ### inc/adcsq_pkg.sv
// Types of the converter sequencer
// Assumes the defs header is on the include path
package adcsq_pkg;
    // Reference pair selection
    typedef enum logic [1:0] {
        ADCSQ_REF_INT = 2'h0,
        ADCSQ_REF_EXT_HI = 2'h1,
        ADCSQ_REF_EXT_LO = 2'h2,
        ADCSQ_REF_EXT_BOTH = 2'h3
    } adcsq_ref_t;

    // Sequencer states, Gray coded along idle, sample, convert, done
    typedef enum logic [1:0] {
        ADCSQ_IDLE = 2'b00,
        ADCSQ_SAMPLE = 2'b01,
        ADCSQ_CONVERT = 2'b11,
        ADCSQ_DONE = 2'b10
    } adcsq_state_t;
endpackage

// ### inc/adcsq_tick_if.sv
// Interface carrying the conversion clock tick between sequencer parts
// Assumes one clock domain
`timescale 1ns/1ps
`default_nettype none
interface adcsq_tick_if;
    logic [7:0] divider;
    logic use_rc;
    logic rc_tick;
    logic tick;
    modport gen (input divider, input use_rc, input rc_tick, output tick);
    modport use_side (output divider, output use_rc, output rc_tick, input tick);
endinterface
`default_nettype wire

// ### hw/adcsq_tick_gen.sv
// Conversion clock tick generator
// Assumes rc_tick is a synchronous one-cycle pulse from the RC oscillator domain
`timescale 1ns/1ps
`default_nettype none
module adcsq_tick_gen (
    input wire logic aclk,
    input wire logic aresetn,
    adcsq_tick_if.gen tk
);
    import adcsq_pkg::*;
    logic [8:0] cnt_ff;
    logic tick_ff;
    logic [8:0] half_cnt;
    logic bus_wrap;

    // Half period is divider+1 bus cycles, period 2*(divider+1)
    assign half_cnt = {1'b0, tk.divider};
    assign bus_wrap = (cnt_ff >= {half_cnt[7:0], 1'b1});
    assign tk.tick = tick_ff;

    ////////////////////////////////////////////////////////////////////////
    // Counter runs only from the bus clock; divider ignored on RC
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_ff <= 9'h000;
            tick_ff <= 1'b0;
        end else if (tk.use_rc) begin
            cnt_ff <= 9'h000;
            tick_ff <= tk.rc_tick;
        end else begin
            cnt_ff <= bus_wrap ? 9'h000 : cnt_ff + 9'h001;
            tick_ff <= bus_wrap;
        end
    end
endmodule
`default_nettype wire

// ### hw/adcsq_input_mux.sv
// Positive/negative input selection for one multiplexer setting
// Assumes codes per the defs header; outputs are combinational
`timescale 1ns/1ps
`default_nettype none
`include "adcsq_defs.svh"
module adcsq_input_mux (
    input wire logic [3:0] pos_sel,
    input wire logic neg_sel,
    input wire logic offset_calibration_enable,
    output logic [3:0] pos_code,
    output logic pos_open,
    output logic pos_is_lowref,
    output logic neg_is_an1
);
    import adcsq_pkg::*;
    // Offset calibration ties both inputs to the low reference
    assign pos_open = !offset_calibration_enable && (pos_sel == `ADCSQ_POS_OPEN);
    assign pos_is_lowref = offset_calibration_enable;
    assign pos_code = offset_calibration_enable ? 4'h0 : pos_sel;
    assign neg_is_an1 = !offset_calibration_enable && neg_sel;
endmodule
`default_nettype wire

// ### hw/adcsq_top.sv
// Converter sequencing control with AXI4-Lite register slave
// Assumes single clock aclk; analog core acknowledges with conv_done pulse
`timescale 1ns/1ps
`default_nettype none
`include "adcsq_defs.svh"
module adcsq_top (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic rc_tick,
    input wire logic manual_convert,
    input wire logic conv_done,
    output logic [3:0] pos_code,
    output logic pos_open,
    output logic pos_is_lowref,
    output logic neg_is_an1,
    output adcsq_pkg::adcsq_ref_t ref_sel,
    output logic sampling,
    output logic converting,
    output logic [3:0] result_addr,
    output logic result_we,
    output logic conv_irq
);
    import adcsq_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Register storage
    logic [31:0] ctrl1_ff, ctrl2_ff, ctrl3_ff, insel_ff, scan_ff;
    logic aw_ff, w_ff;
    logic [11:0] awaddr_ff;
    logic [31:0] wdata_ff;
    logic [3:0] wstrb_ff;
    logic bvalid_ff, rvalid_ff;
    logic [1:0] bresp_ff, rresp_ff;
    logic [31:0] rdata_ff;

    // Sequencer state
    adcsq_state_t state_ff, nxt_state;
    logic [4:0] tad_cnt_ff;
    logic [3:0] seq_cnt_ff;
    logic [3:0] scan_idx_ff;
    logic use_b_ff;
    logic fill_half_ff;
    logic [3:0] wr_ptr_ff;
    logic [3:0] waddr_ff;
    logic irq_ff, we_ff;

    // Write channel capture and decode
    wire do_write = aw_ff && w_ff && !bvalid_ff;
    wire [31:0] wmask = {{8{wstrb_ff[3]}}, {8{wstrb_ff[2]}}, {8{wstrb_ff[1]}},
        {8{wstrb_ff[0]}}};
    wire hit_c1 = (awaddr_ff == `ADCSQ_OFF_CTRL1);
    wire hit_c2 = (awaddr_ff == `ADCSQ_OFF_CTRL2);
    wire hit_c3 = (awaddr_ff == `ADCSQ_OFF_CTRL3);
    wire hit_in = (awaddr_ff == `ADCSQ_OFF_INSEL);
    wire hit_sc = (awaddr_ff == `ADCSQ_OFF_SCAN);
    wire w_ok = hit_c1 | hit_c2 | hit_c3 | hit_in | hit_sc;

    // Field extraction
    wire mod_on = ctrl1_ff[`ADCSQ_BIT_ON];
    wire [2:0] trig = ctrl1_ff[`ADCSQ_TRIG_LSB +: 3];
    wire auto_start = ctrl1_ff[`ADCSQ_BIT_ASAM];
    wire [2:0] ref_code = ctrl2_ff[`ADCSQ_REF_LSB +: 3];
    wire offset_calibration_enable = ctrl2_ff[`ADCSQ_BIT_OFFSET_CALIBRATION_ENABLE];
    wire scan_en = ctrl2_ff[`ADCSQ_BIT_SCAN];
    wire [3:0] spi_n = ctrl2_ff[`ADCSQ_SPI_LSB +: 4];
    wire split = ctrl2_ff[`ADCSQ_BIT_SPLIT];
    wire alt = ctrl2_ff[`ADCSQ_BIT_ALT];
    wire [4:0] samt = ctrl3_ff[`ADCSQ_SAMT_LSB +: 5];
    wire [15:0] smask = scan_ff[15:0];

    // Conversion clock tick
    adcsq_tick_if tk ();
    assign tk.divider = ctrl3_ff[`ADCSQ_DIV_LSB +: 8];
    assign tk.use_rc = ctrl3_ff[`ADCSQ_BIT_CLKSRC];
    assign tk.rc_tick = rc_tick;
    adcsq_tick_gen u_tick (
        .aclk(aclk),
        .aresetn(aresetn),
        .tk(tk)
    );

    ////////////////////////////////////////////////////////////////////////
    // AXI4-Lite write path: take address and data in any order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_ff <= 1'b0;
            w_ff <= 1'b0;
            awaddr_ff <= 12'h000;
            wdata_ff <= 32'h00000000;
            wstrb_ff <= 4'h0;
        end else begin
            if (s_axi_awvalid && !aw_ff) begin
                aw_ff <= 1'b1;
                awaddr_ff <= {s_axi_awaddr[11:2], 2'b00};
            end else if (do_write) begin
                aw_ff <= 1'b0;
            end
            if (s_axi_wvalid && !w_ff) begin
                w_ff <= 1'b1;
                wdata_ff <= s_axi_wdata;
                wstrb_ff <= s_axi_wstrb;
            end else if (do_write) begin
                w_ff <= 1'b0;
            end
        end
    end

    // Write response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_ff <= 1'b0;
            bresp_ff <= 2'h0;
        end else if (do_write) begin
            bvalid_ff <= 1'b1;
            bresp_ff <= w_ok ? 2'h0 : 2'h2;
        end else if (s_axi_bready) begin
            bvalid_ff <= 1'b0;
        end
    end
    assign s_axi_awready = !aw_ff;
    assign s_axi_wready = !w_ff;
    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp = bresp_ff;

    // Merge a write under the byte strobes and the implemented-bit mask
    function automatic logic [31:0] merge(input logic [31:0] old,
        input logic [31:0] val, input logic [31:0] bm, input logic [31:0] im);
        merge = ((old & ~bm) | (val & bm)) & im;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Control registers; fill status is hardware-owned and not stored here
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl1_ff <= `ADCSQ_RESET_VALUE;
            ctrl2_ff <= `ADCSQ_RESET_VALUE;
            ctrl3_ff <= `ADCSQ_RESET_VALUE;
            insel_ff <= `ADCSQ_RESET_VALUE;
            scan_ff <= `ADCSQ_RESET_VALUE;
        end else if (do_write) begin
            if (hit_c1) ctrl1_ff <= merge(ctrl1_ff, wdata_ff, wmask, `ADCSQ_CTRL1_MASK);
            if (hit_c2) ctrl2_ff <= merge(ctrl2_ff, wdata_ff, wmask, `ADCSQ_CTRL2_MASK);
            if (hit_c3) ctrl3_ff <= merge(ctrl3_ff, wdata_ff, wmask, `ADCSQ_CTRL3_MASK);
            if (hit_in) insel_ff <= merge(insel_ff, wdata_ff, wmask, `ADCSQ_INSEL_MASK);
            if (hit_sc) scan_ff <= merge(scan_ff, wdata_ff, wmask, `ADCSQ_SCAN_MASK);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read decode; fill status merged into control two
    wire [31:0] stat_word = {24'h000000, irq_ff, fill_half_ff, wr_ptr_ff,
        state_ff};
    wire [31:0] c2_read = ctrl2_ff | ({31'h0, fill_half_ff} << `ADCSQ_BIT_FILL);
    wire [11:0] raddr = {s_axi_araddr[11:2], 2'b00};
    logic [31:0] rd_word;
    logic rd_ok;
    always_comb begin
        rd_ok = 1'b1;
        unique case (raddr)
            `ADCSQ_OFF_CTRL1: rd_word = ctrl1_ff;
            `ADCSQ_OFF_CTRL2: rd_word = c2_read;
            `ADCSQ_OFF_CTRL3: rd_word = ctrl3_ff;
            `ADCSQ_OFF_INSEL: rd_word = insel_ff;
            `ADCSQ_OFF_SCAN: rd_word = scan_ff;
            `ADCSQ_OFF_STAT: rd_word = stat_word;
            default: begin
                rd_word = 32'h00000000;
                rd_ok = 1'b0;
            end
        endcase
    end

    // Read response, one cycle after address accept
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_ff <= 1'b0;
            rdata_ff <= 32'h00000000;
            rresp_ff <= 2'h0;
        end else if (s_axi_arvalid && !rvalid_ff) begin
            rvalid_ff <= 1'b1;
            rdata_ff <= rd_word;
            rresp_ff <= rd_ok ? 2'h0 : 2'h2;
        end else if (s_axi_rready) begin
            rvalid_ff <= 1'b0;
        end
    end
    assign s_axi_arready = !rvalid_ff;
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rdata = rdata_ff;
    assign s_axi_rresp = rresp_ff;

    ////////////////////////////////////////////////////////////////////////
    // Reference pair decode
    adcsq_ref_t ref_nxt;
    assign ref_nxt = ref_code[2] ? ADCSQ_REF_INT : adcsq_ref_t'(ref_code[1:0]);

    // Next scan index: first set mask bit above current, wrapping
    logic [3:0] scan_next;
    logic [3:0] probe;
    always_comb begin
        scan_next = scan_idx_ff;
        probe = 4'h0;
        for (int k = 16; k >= 1; k--) begin
            probe = scan_idx_ff + 4'(k);
            if (smask[probe]) scan_next = probe;
        end
    end

    // Multiplexer setting in use and scan mapping
    wire [3:0] pos_a = insel_ff[`ADCSQ_POS_A_LSB +: 4];
    wire [3:0] pos_b = insel_ff[`ADCSQ_POS_B_LSB +: 4];
    wire neg_a = insel_ff[`ADCSQ_BIT_NEG_A];
    wire neg_b = insel_ff[`ADCSQ_BIT_NEG_B];
    wire sel_b = alt && use_b_ff;
    wire [3:0] mux_pos = sel_b ? pos_b : pos_a;
    // Mask places 0-12 name pins; places beyond the fitted pin count have none
    wire absent = (scan_idx_ff < 4'hD) && (5'(scan_idx_ff) >= 5'(`ADCSQ_NUM_PINS));
    wire [3:0] scan_pos = scan_idx_ff; // 13 temperature, 14 ref, 15 open
    wire [3:0] eff_pos = scan_en ? scan_pos : mux_pos;
    wire scan_low = scan_en && absent;
    logic [3:0] m_code;
    logic m_open, m_low, m_neg;
    adcsq_input_mux u_mux (
        .pos_sel(eff_pos),
        .neg_sel(sel_b ? neg_b : neg_a),
        .offset_calibration_enable(offset_calibration_enable || scan_low),
        .pos_code(m_code),
        .pos_open(m_open),
        .pos_is_lowref(m_low),
        .neg_is_an1(m_neg)
    );

    ////////////////////////////////////////////////////////////////////////
    // Sequencer transitions
    wire auto_trig = (trig == `ADCSQ_TRIG_AUTO);
    // Under the auto trigger, the tick that completes a nonzero programmed count of periods ends sampling
    wire samt_done = (tad_cnt_ff >= samt - 5'h01) && (samt != 5'h00);
    wire end_sample = auto_trig ? (tk.tick && samt_done) : manual_convert;
    wire seq_last = (seq_cnt_ff == spi_n);
    wire scan_step = scan_en && (state_ff == ADCSQ_IDLE) && (nxt_state == ADCSQ_SAMPLE);
    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            ADCSQ_IDLE: if (mod_on && auto_start) nxt_state = ADCSQ_SAMPLE;
            ADCSQ_SAMPLE: if (end_sample) nxt_state = ADCSQ_CONVERT;
            ADCSQ_CONVERT: if (conv_done) nxt_state = ADCSQ_DONE;
            ADCSQ_DONE: nxt_state = ADCSQ_IDLE;
        endcase
        if (!mod_on) nxt_state = ADCSQ_IDLE;
    end

    // Sequencer registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_ff <= ADCSQ_IDLE;
            tad_cnt_ff <= 5'h00;
            seq_cnt_ff <= 4'h0;
            scan_idx_ff <= 4'hF;
            waddr_ff <= 4'h0;
            use_b_ff <= 1'b0;
            fill_half_ff <= 1'b0;
            wr_ptr_ff <= 4'h0;
            irq_ff <= 1'b0;
            we_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            irq_ff <= 1'b0;
            we_ff <= 1'b0;
            if (state_ff != ADCSQ_SAMPLE) tad_cnt_ff <= 5'h00;
            else if (tk.tick && tad_cnt_ff != 5'h1F) tad_cnt_ff <= tad_cnt_ff + 5'h01;
            // Land on the next included input as each sample starts
            if (!mod_on) scan_idx_ff <= 4'hF;
            else if (scan_step) scan_idx_ff <= scan_next;
            if (!mod_on) begin
                seq_cnt_ff <= 4'h0;
                use_b_ff <= 1'b0;
                wr_ptr_ff <= 4'h0;
            end else if (state_ff == ADCSQ_DONE) begin
                we_ff <= 1'b1;
                wr_ptr_ff <= wr_ptr_ff + 4'h1;
                use_b_ff <= !use_b_ff;
                waddr_ff <= wr_ptr_ff; // Location of the result written now
                if (seq_last) begin
                    seq_cnt_ff <= 4'h0;
                    irq_ff <= 1'b1;
                    fill_half_ff <= split ? !fill_half_ff : 1'b0;
                    wr_ptr_ff <= (split && !fill_half_ff) ? `ADCSQ_HALF_BASE : 4'h0;
                end else begin
                    seq_cnt_ff <= seq_cnt_ff + 4'h1;
                end
            end
        end
    end

    // Registered outputs to the analog core
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pos_code <= 4'h0;
            pos_open <= 1'b0;
            pos_is_lowref <= 1'b0;
            neg_is_an1 <= 1'b0;
            ref_sel <= ADCSQ_REF_INT;
            sampling <= 1'b0;
            converting <= 1'b0;
        end else begin
            pos_code <= m_code;
            pos_open <= m_open;
            pos_is_lowref <= m_low;
            neg_is_an1 <= m_neg;
            ref_sel <= ref_nxt;
            sampling <= (nxt_state == ADCSQ_SAMPLE); // Tracks state_ff exactly
            converting <= (nxt_state == ADCSQ_CONVERT);
        end
    end
    assign result_addr = waddr_ff;
    assign result_we = we_ff;
    assign conv_irq = irq_ff;
endmodule
`default_nettype wire

// ### verification/adcsq_top_asserts.sv
// Concurrent checks on the sequencer top ports
// Assumes a bind onto adcsq_top and one clock domain on aclk
`timescale 1ns/1ps
`default_nettype none
module adcsq_top_asserts (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic conv_done,
    input wire logic [3:0] pos_code,
    input wire logic pos_open,
    input wire logic pos_is_lowref,
    input wire logic neg_is_an1,
    input wire logic sampling,
    input wire logic converting,
    input wire logic result_we,
    input wire logic conv_irq
);
    // One domain; reset silences every check
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    ////////////////////////////////////////////////////////////
    // Read answers come the cycle after acceptance; bus answers stand until taken
    bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped early");
    read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    ////////////////////////////////////////////////////////////
    // Sequencer phases
    phase_excl_a: assert property (!(sampling && converting))
        else $error("sampling and converting together");
    convert_entry_a: assert property ($rose(converting) |-> $past(sampling))
        else $error("conversion without sampling");
    convert_hold_a: assert property (converting && !conv_done |=> converting)
        else $error("conversion ended without done");
    result_after_a: assert property ($rose(result_we) |-> $past(converting) || $past(converting, 2))
        else $error("result write without conversion");
    irq_with_we_a: assert property (conv_irq |-> result_we)
        else $error("interrupt without completed sequence");
    irq_pulse_a: assert property (conv_irq |=> !conv_irq)
        else $error("interrupt longer than one cycle");
    ////////////////////////////////////////////////////////////
    // Input routing
    lowref_both_a: assert property (pos_is_lowref |-> !neg_is_an1 && pos_code == 4'h0)
        else $error("offset calibration routing wrong");
    open_route_a: assert property (pos_open |-> !pos_is_lowref)
        else $error("open input routed to low reference");
endmodule
bind adcsq_top adcsq_top_asserts u_chk (.*);
`default_nettype wire

// ### verification/adcsq_core_model.sv
// Behavioural model of the analog sample-and-hold and converter core
// Assumes converting is a level; lat sets how many cycles the answer takes
`timescale 1ns/1ps
`default_nettype none
module adcsq_core_model (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic converting,
    input wire logic [3:0] lat,
    output logic conv_done
);
    logic [3:0] cnt_ff;
    logic done_ff;
    // Count conversion cycles, answer with a one-cycle done pulse
    always_ff @(posedge aclk) begin
        if (!aresetn || !converting || done_ff) begin
            cnt_ff <= 4'h0;
            done_ff <= 1'b0;
        end else begin
            cnt_ff <= cnt_ff + 4'h1;
            done_ff <= (cnt_ff == lat);
        end
    end
    assign conv_done = done_ff;
endmodule
`default_nettype wire

// ### verification/tb.sv
// Self-checking bench of the converter sequencer
// Assumes the defs header on the include path and the core model beside it
`timescale 1ns/1ps
`default_nettype none
`include "adcsq_defs.svh"
module tb;
    import adcsq_pkg::*;
    logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
    logic s_axi_rready, rc_tick, manual_convert, conv_done, s_axi_awready, s_axi_wready;
    logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, pos_open, pos_is_lowref, neg_is_an1;
    logic sampling, converting, result_we, conv_irq;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb, pos_code, result_addr, core_lat, codes [2];
    logic [1:0] s_axi_bresp, s_axi_rresp;
    adcsq_ref_t ref_sel;
    logic [11:0] off [6] = '{`ADCSQ_OFF_CTRL1, `ADCSQ_OFF_CTRL2, `ADCSQ_OFF_CTRL3,
        `ADCSQ_OFF_INSEL, `ADCSQ_OFF_SCAN, `ADCSQ_OFF_STAT};
    logic [31:0] msk [6] = '{`ADCSQ_CTRL1_MASK, `ADCSQ_CTRL2_MASK, `ADCSQ_CTRL3_MASK,
        `ADCSQ_INSEL_MASK, `ADCSQ_SCAN_MASK, 32'h00000000};
    int n_fail = 0, tests_run = 0, nseq = 0, ptr = 0, half = 0, spi = 0, rc_cnt = 0;
    bit split = 0;
    adcsq_top dut (.*);
    adcsq_core_model u_core (.aclk(aclk), .aresetn(aresetn), .converting(converting),
        .lat(core_lat), .conv_done(conv_done));
    ////////////////////////////////////////////////////////////
    // Clock and a free-running RC tick every 7 cycles
    initial begin
        aclk = 1'b0;
        forever #2.5 aclk = ~aclk;
    end
    always @(posedge aclk) begin
        rc_cnt <= (rc_cnt == 6) ? 0 : rc_cnt + 1;
        rc_tick <= (rc_cnt == 6);
    end
    ////////////////////////////////////////////////////////////
    // Reporting
    task automatic close_out;
        $display("comparisons %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic give_up;
        n_fail++;
        $display("wrong value at %0t: wait ran out", $time);
        close_out();
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_len(input int got, input int lo, input int hi);
        tests_run++;
        if (got < lo || got > hi) begin
            n_fail++;
            $display("wrong value at %0t: length %0d outside %0d..%0d", $time, got, lo, hi);
        end
    endtask
    ////////////////////////////////////////////////////////////
    // Register bus master
    task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
        int k;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (k = 0; k < 99; k++) begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) break;
        end
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        if (k == 99) give_up();
    endtask
    task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        int k;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (k = 0; k < 99; k++) begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) break;
        end
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        if (k == 99) give_up();
    endtask
    ////////////////////////////////////////////////////////////
    // Sequence runner with the interrupt and pointer model
    task automatic wait_samp;
        int k;
        k = 0;
        while (!sampling) begin
            @(posedge aclk);
            k++;
            if (k > 3000) give_up();
        end
    endtask
    task automatic run_seq(input int n, input int lo, input int hi, input bit man);
        int i, k, len;
        logic [3:0] pc;
        bit irq_e;
        for (i = 0; i < n; i++) begin
            wait_samp();
            len = 0;
            while (sampling) begin
                pc = pos_code;
                @(posedge aclk);
                len++;
                manual_convert <= man && len == 40;
                if (len > 900) give_up();
            end
            k = 0;
            while (!result_we) begin
                @(posedge aclk);
                k++;
                if (k > 900) give_up();
            end
            chk_len(len, lo, hi);
            chk(pc, codes[i % 2]);
            nseq++;
            irq_e = (nseq == spi + 1);
            chk({split ? result_addr : 4'h0, conv_irq}, {ptr[3:0], irq_e});
            if (irq_e) begin
                nseq = 0;
                half ^= 1;
            end
            ptr = !split ? 0 : irq_e ? half * 8 : ptr + 1;
        end
    endtask
    ////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        logic [31:0] d, d2;
        logic [1:0] r;
        int i, v;
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
        {s_axi_rready, manual_convert, s_axi_awaddr, s_axi_araddr} = '0;
        s_axi_wdata = 32'h00000000;
        s_axi_wstrb = 4'hF;
        core_lat = 4'h1;
        void'($urandom(38));
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        // Reset values, unmapped place, masked read-back
        for (i = 0; i < 6; i++) begin
            rd(off[i], d, r);
            chk(d, 32'h00000000);
        end
        rd(12'h018, d, r);
        chk({d, r}, 34'h2);
        wr(12'h018, 32'hFFFFFFFF, r);
        chk(r, 2'h2);
        for (i = 0; i < 15; i++) begin
            v = 1 + i % 5;
            d = $urandom;
            if (v == 2) d[8] = 1'b1;
            wr(off[v], d, r);
            rd(off[v], d2, r);
            chk(d2, d & msk[v]);
        end
        // Reference pair decode for every code
        for (v = 0; v < 8; v++) begin
            wr(off[1], v << 13, r);
            repeat (2) @(posedge aclk);
            chk(ref_sel, (v > 3) ? 0 : v);
        end
        // Every positive code, negative select following bit 0
        for (v = 0; v < 16; v++) begin
            wr(off[3], ((v & 1) << 23) | (v << 16), r);
            repeat (2) @(posedge aclk);
            chk({pos_open, neg_is_an1, pos_is_lowref, pos_code == v[3:0] || v == 15},
                {v == 15, v[0], 1'b0, 1'b1});
        end
        wr(off[1], 32'h00001000, r);
        repeat (2) @(posedge aclk);
        chk({pos_is_lowref, neg_is_an1, pos_code}, 6'h20);
        // Split buffer, alternate A/B, auto trigger on the bus clock
        codes = '{4'h3, 4'h5};
        spi = 2;
        split = 1;
        wr(off[3], 32'h05030000, r);
        wr(off[2], 32'h00000201, r);
        wr(off[1], 32'h0000000B, r);
        wr(off[0], 32'h000080E4, r);
        run_seq(4, 4, 11, 0);
        wait_samp();
        wr(off[0], 32'h00000000, r);
        rd(off[1], d, r);
        chk(d, 32'h0000008B);
        // Scan of inputs 1 and 4 on the RC clock, divider at its top value
        {nseq, ptr, half, spi, split} = '0;
        codes = '{4'h1, 4'h4};
        core_lat <= 4'h9;
        wr(off[4], 32'h00000012, r);
        wr(off[2], 32'h000083FF, r);
        wr(off[1], 32'h00000400, r);
        wr(off[0], 32'h000080E4, r);
        run_seq(3, 14, 24, 0);
        // Manual trigger: the short sample time must not end sampling
        wait_samp();
        wr(off[0], 32'h00000000, r);
        nseq = 0;
        codes = '{4'h3, 4'h3};
        wr(off[1], 32'h00000000, r);
        wr(off[2], 32'h00000100, r);
        wr(off[0], 32'h00008004, r);
        run_seq(1, 41, 45, 1);
        close_out();
    end
endmodule
`default_nettype wire
